// ===== rtl/console_run_control.sv
`timescale 1ns/1ns
// Summary of operation
// - skip ops other than sense act only as upper: condition true gives full exit, else half
// - lower sense op repeats through half exit until condition, then full
// - run executes continuously; each step executes one instruction, halts, except the first step after master clear, which only fetches
// - run/step ignored while buffers busy; step still sets first stop
// - step beats run; step while running stops the machine
// - switch contacts become single pulses; display blanks, delayed pulse
// - run after master clear: jump exit fetch, second stop cleared, full speed
// - step after master clear: fetch pair, copy stop flag, halt fetch
// - step otherwise: execute current, copy flag at next fetch, halt there
// - run otherwise: clear second stop, execute current, keep running
// - master clear zeroes registers, address to octal 20, sets initial start
// - master clear keeps storage, hold rank and some flags unchanged
// - external clear pulses all equipment, any time, immediately
// - three jump switches give manual conditions for jump designators
// - three stop switches gate the stop instruction by designator
// - repeat mode blocks address advance on full fetch; jumps still load
// - sweep mode executes nothing, alternating full and half fetches
// - sweep full fetch shows upper half, half fetch lower half
// - free-running two-phase master clock, 2.5 MHz, 0.2 us phases
// - subroutine return jump loads saved address, fetch via jump exit, or half exit when exec_half
// - the five momentary switch inputs each give one clocked pulse; selectors stay levels
// - jump exit fetch does not advance the address, full exit does
module console_run_control
  import console_pkg::*;
#(
  parameter int DELAY_TICKS = console_pkg::DISPLAY_DELAY_TICKS
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // console switches
  input  wire logic                        start_sw,
  input  wire logic                        step_sw,
  input  wire logic                        neutral_sw,
  input  wire logic                        clear_dn_sw,
  input  wire logic                        clear_up_sw,
  input  wire logic [2:0]                  sel_jump_sw,
  input  wire logic [2:0]                  sel_stop_sw,
  input  wire logic                        repeat_sw,
  input  wire logic                        sweep_sw,
  input  wire logic                        buffer_active,
  // storage read
  output logic                             mem_req,
  output logic [console_pkg::ADDR_W-1:0]   mem_addr,
  input  wire logic                        mem_ack,
  input  wire logic [console_pkg::WORD_W-1:0] mem_rdata,
  // execution unit
  output logic                             exec_req,
  output logic [console_pkg::HALF_W-1:0]   exec_instr,
  output logic                             exec_lower,
  input  wire logic                        exec_done,
  input  wire logic                        exec_cond,
  input  wire logic                        exec_load_p,
  input  wire logic [console_pkg::ADDR_W-1:0] exec_addr,
  input  wire logic                        exec_half,
  input  wire logic                        exec_stop,
  // console and equipment
  output logic                             display_on,
  output logic                             ext_master_clear,
  output logic                             even_phase,
  output logic                             odd_phase,
  // axi4-lite slave
  input  wire logic [console_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [console_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  import console_pkg::*;

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    return a == CTRL_OFF || a == STATUS_OFF || a == PADDR_OFF || a == PCR_OFF;
  endfunction

  // designator 0/4 unconditional, else switch (j-1) mod 4
  function automatic logic sw_sel(input logic [2:0] j, input logic [2:0] sw);
    logic [1:0] k;
    k = j[1:0];
    return (k == 2'h0) ? 1'b1 : sw[k - 2'h1];
  endfunction

  // master clock phases
  logic [4:0]       ph_cnt_reg;
  logic             even_reg;
  wire logic        ph_end  = ph_cnt_reg == 5'(GATE_CYCLES - 1);
  wire logic        mc_tick = ph_end && !even_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_cnt_reg <= '0;
      even_reg   <= 1'b1;
    end else begin
      ph_cnt_reg <= ph_end ? 5'h00 : ph_cnt_reg + 5'h01;
      if (ph_end) even_reg <= !even_reg;
    end
  end
  assign even_phase = even_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) odd_phase <= 1'b0;
    else        odd_phase <= ph_end ? even_reg : !even_reg;
  end

  // switch resynchronisers; pulses from stage 2 against stage 3
  logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync3_reg;
  wire logic [SYNC_W-1:0] raw_sw = {sweep_sw, repeat_sw, sel_stop_sw,
    sel_jump_sw, clear_up_sw, clear_dn_sw, neutral_sw, step_sw, start_sw};
  wire logic [4:0] sw_pulse = sync2_reg[4:0] & ~sync3_reg[4:0];
  wire logic [2:0] jump_lvl = sync2_reg[7:5];
  wire logic [2:0] stop_lvl = sync2_reg[10:8];
  wire logic       repeat_on = sync2_reg[11];
  wire logic       sweep_on  = sync2_reg[12];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= raw_sw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // software command pulses from the control register
  logic       sw_run_reg, sw_step_reg, sw_mclr_reg, sw_xclr_reg;
  logic       armed_reg;
  wire logic  mclr_p = sw_pulse[3] || sw_mclr_reg;
  wire logic  run_p  = (sw_pulse[0] && armed_reg) || sw_run_reg;
  wire logic  step_p = (sw_pulse[1] && armed_reg) || sw_step_reg;

  // contact must pass neutral before another start or step counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)                      armed_reg <= 1'b1;
    else if (sw_pulse[2])            armed_reg <= 1'b1;
    else if (sw_pulse[0] || sw_pulse[1]) armed_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ext_master_clear <= 1'b0;
    else        ext_master_clear <= sw_pulse[4] || sw_xclr_reg;
  end

  // display settling delay, counted in master clock periods
  logic [31:0] dly_cnt_reg;
  logic        dly_step_reg;
  wire logic   dly_busy = dly_cnt_reg != 32'h0;
  wire logic   dly_done = mc_tick && dly_cnt_reg == 32'h1;
  wire logic   run_go   = dly_done && !dly_step_reg;
  wire logic   step_go  = dly_done && dly_step_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_cnt_reg  <= '0;
      dly_step_reg <= 1'b0;
    end else if (mclr_p) begin
      dly_cnt_reg  <= '0;
      dly_step_reg <= 1'b0;
    end else if (run_p || step_p) begin
      dly_cnt_reg  <= 32'(DELAY_TICKS);
      dly_step_reg <= step_p || (dly_busy && dly_step_reg);
    end else if (mc_tick && dly_busy) begin
      dly_cnt_reg  <= dly_cnt_reg - 32'h1;
    end
  end

  // run control sequencer
  run_state_e        state_reg, state_next;
  exit_e             exit_reg, exit_next;
  logic [ADDR_W-1:0] p_reg, p_next;
  logic [HALF_W-1:0] pcr_reg, pcr_next;
  logic [HALF_W-1:0] hold_reg, hold_next;   // instruction_hold_rank
  logic lower_reg, lower_next;
  logic first_reg, first_next;              // first_stop_ff_cell
  logic second_reg, second_next;            // second_stop_flag
  logic init_reg, init_next;                // initial_start_flag
  logic resexec_reg, resexec_next;
  logic mreq_next, xreq_next;

  wire logic [5:0] op   = pcr_reg[OP_MSB:OP_LSB];
  wire logic [2:0] jdes = pcr_reg[J_MSB:J_LSB];
  wire logic is_jmp  = op == OP_JUMP || op == OP_STOP;
  wire logic is_ret  = is_jmp && jdes[2];
  wire logic is_efs  = op == OP_EXTFN && jdes == J_SENSE;
  wire logic is_skip = op == OP_SKIP36 || op == OP_SKIP37 ||
                       op == OP_SKIP54 || is_efs ||
                       (op >= OP_SKIP64 && op <= OP_SKIP67);
  wire logic jcond   = (op == OP_STOP) || sw_sel(jdes, jump_lvl);
  wire logic stop_c  = op == OP_STOP && jdes != J_SENSE &&
                       sw_sel(jdes, stop_lvl);
  wire exit_e normal_exit = lower_reg ? EXIT_FULL : EXIT_HALF;
  wire exit_e skip_exit   =
    (is_skip && (!lower_reg || is_efs)) ?
      (exec_cond ? EXIT_FULL : EXIT_HALF) : normal_exit;

  always_comb begin
    state_next   = state_reg;
    exit_next    = exit_reg;
    p_next       = p_reg;
    pcr_next     = pcr_reg;
    hold_next    = hold_reg;
    lower_next   = lower_reg;
    first_next   = first_reg;
    second_next  = second_reg;
    init_next    = init_reg;
    resexec_next = resexec_reg;
    mreq_next    = mem_req;
    xreq_next    = exec_req;
    if (mclr_p) begin
      // hold rank deliberately left alone, like storage
      state_next   = S_STOP;
      p_next       = P_INIT;
      pcr_next     = '0;
      lower_next   = 1'b0;
      first_next   = 1'b0;
      second_next  = 1'b0;
      init_next    = 1'b1;
      resexec_next = 1'b0;
      exit_next    = EXIT_FULL;
      mreq_next    = 1'b0;
      xreq_next    = 1'b0;
    end else begin
      unique case (state_reg)
        S_STOP: begin
          if (!buffer_active && (run_go || step_go)) begin
            if (!step_go) second_next = 1'b0;
            if (init_reg) begin
              init_next  = 1'b0;
              exit_next  = EXIT_JUMP;
              state_next = S_RNI;
            end else if (resexec_reg) begin
              state_next = S_EXEC;
            end else begin
              state_next = S_RNI;
            end
          end
        end
        S_RNI: begin
          unique case (exit_reg)
            EXIT_FULL: begin
              if (!repeat_on) p_next = p_reg + 15'h0001;
              mreq_next  = 1'b1;
              state_next = S_MEM;
            end
            EXIT_JUMP: begin
              mreq_next  = 1'b1;
              state_next = S_MEM;
            end
            EXIT_HALF: begin
              pcr_next   = hold_reg;
              lower_next = 1'b1;
              state_next = S_CHECK;
            end
            default: state_next = S_STOP;
          endcase
        end
        S_MEM: begin
          if (mem_ack) begin
            mreq_next  = 1'b0;
            pcr_next   = mem_rdata[WORD_W-1:HALF_W];
            hold_next  = mem_rdata[HALF_W-1:0];
            lower_next = 1'b0;
            state_next = S_CHECK;
          end
        end
        S_CHECK: begin
          second_next = first_reg;
          if (first_reg) begin
            first_next   = 1'b0;
            resexec_next = !sweep_on;
            exit_next    = normal_exit;
            state_next   = S_STOP;
          end else if (sweep_on) begin
            exit_next  = normal_exit;
            state_next = S_RNI;
          end else begin
            state_next = S_EXEC;
          end
        end
        S_EXEC: begin
          if (is_jmp && !jcond) begin
            exit_next  = normal_exit;
            state_next = S_RNI;
          end else if (is_jmp && !is_ret) begin
            p_next     = pcr_reg[M_MSB:0];
            exit_next  = EXIT_JUMP;
            resexec_next = 1'b0;
            state_next = stop_c ? S_STOP : S_RNI;
          end else begin
            xreq_next  = 1'b1;
            state_next = S_WAIT;
          end
        end
        S_WAIT: begin
          if (exec_done) begin
            xreq_next = 1'b0;
            if (exec_load_p) begin
              p_next     = exec_addr;
              exit_next  = exec_half ? EXIT_HALF : EXIT_JUMP;
              state_next = S_RNI;
            end else if (exec_stop) begin
              exit_next    = normal_exit;
              resexec_next = 1'b0;
              state_next   = S_STOP;
            end else begin
              exit_next  = skip_exit;
              state_next = S_RNI;
            end
          end
        end
      endcase
      // a step in flight always leaves the first stop set
      if (step_go && (buffer_active || state_reg != S_STOP || !resexec_reg
          || init_reg || state_reg == S_STOP))
        first_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= S_STOP;
      exit_reg    <= EXIT_FULL;
      p_reg       <= P_INIT;
      pcr_reg     <= '0;
      hold_reg    <= '0;
      lower_reg   <= 1'b0;
      first_reg   <= 1'b0;
      second_reg  <= 1'b0;
      init_reg    <= 1'b1;
      resexec_reg <= 1'b0;
      mem_req     <= 1'b0;
      exec_req    <= 1'b0;
      display_on  <= 1'b1;
    end else begin
      state_reg   <= state_next;
      exit_reg    <= exit_next;
      p_reg       <= p_next;
      pcr_reg     <= pcr_next;
      hold_reg    <= hold_next;
      lower_reg   <= lower_next;
      first_reg   <= first_next;
      second_reg  <= second_next;
      init_reg    <= init_next;
      resexec_reg <= resexec_next;
      mem_req     <= mreq_next;
      exec_req    <= xreq_next;
      display_on  <= state_next == S_STOP && !(run_p || step_p) &&
                     !(dly_busy && !dly_done);
    end
  end

  assign mem_addr   = p_reg;
  assign exec_instr = pcr_reg;
  assign exec_lower = lower_reg;

  // axi4-lite: address and data taken in either order
  logic              aw_hold_reg, w_hold_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  wire logic         do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  wire logic         ctrl_wr  = do_write && awaddr_reg == CTRL_OFF &&
                                wstrb_reg[0];
  wire logic         do_read  = s_axi_arvalid && s_axi_arready;
  wire logic [31:0]  status_w = {22'h0, sweep_on, repeat_on, buffer_active,
    dly_busy, display_on, lower_reg, second_reg, first_reg, init_reg,
    state_reg != S_STOP};
  wire logic [31:0]  rd_mux =
    (s_axi_araddr == STATUS_OFF) ? status_w :
    (s_axi_araddr == PADDR_OFF)  ? {17'h0, p_reg} :
    (s_axi_araddr == PCR_OFF)    ? {8'h0, pcr_reg} : 32'h0;

  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= '0;
      wstrb_reg    <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control bits are self-clearing command strobes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_run_reg  <= 1'b0;
      sw_step_reg <= 1'b0;
      sw_mclr_reg <= 1'b0;
      sw_xclr_reg <= 1'b0;
    end else begin
      sw_run_reg  <= ctrl_wr && wdata_reg[CTRL_RUN];
      sw_step_reg <= ctrl_wr && wdata_reg[CTRL_STEP];
      sw_mclr_reg <= ctrl_wr && wdata_reg[CTRL_MCLR];
      sw_xclr_reg <= ctrl_wr && wdata_reg[CTRL_XCLR];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== rtl/console_pkg.sv
package console_pkg;

  // timing
  localparam int  CLK_PERIOD_NS = 20;
  localparam real MC_FREQ_MHZ   = 2.5;
  localparam int  MC_PERIOD_NS  = $rtoi(1000.0 / MC_FREQ_MHZ);
  localparam real GATE_US       = 0.2;
  localparam int  GATE_CYCLES   = $rtoi(GATE_US * 1000.0 / CLK_PERIOD_NS);
  localparam real DISPLAY_DELAY_MS    = 16.6;
  localparam int  DISPLAY_DELAY_TICKS =
    $rtoi(DISPLAY_DELAY_MS * 1.0e6 / MC_PERIOD_NS + 0.999);

  // word layout
  localparam int ADDR_W = 15;
  localparam int HALF_W = 24;
  localparam int WORD_W = 48;
  localparam int OP_MSB = 23;
  localparam int OP_LSB = 18;
  localparam int J_MSB  = 17;
  localparam int J_LSB  = 15;
  localparam int M_MSB  = 14;
  localparam int SYNC_W = 13;

  localparam logic [ADDR_W-1:0] P_INIT = 15'h0010;

  // operation codes
  localparam logic [5:0] OP_JUMP   = 6'h3d;
  localparam logic [5:0] OP_STOP   = 6'h3e;
  localparam logic [5:0] OP_SKIP36 = 6'h1e;
  localparam logic [5:0] OP_SKIP37 = 6'h1f;
  localparam logic [5:0] OP_SKIP54 = 6'h2c;
  localparam logic [5:0] OP_SKIP64 = 6'h34;
  localparam logic [5:0] OP_SKIP67 = 6'h37;
  localparam logic [5:0] OP_EXTFN  = 6'h3c;
  localparam logic [2:0] J_SENSE   = 3'h7;

  // register map
  localparam int          AXI_AW     = 8;
  localparam logic [7:0]  CTRL_OFF   = 8'h00;
  localparam logic [7:0]  STATUS_OFF = 8'h04;
  localparam logic [7:0]  PADDR_OFF  = 8'h08;
  localparam logic [7:0]  PCR_OFF    = 8'h0c;
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_STEP  = 1;
  localparam int CTRL_MCLR  = 2;
  localparam int CTRL_XCLR  = 3;
  localparam int ST_RUNNING = 0;
  localparam int ST_INIT    = 1;
  localparam int ST_FIRST   = 2;
  localparam int ST_SECOND  = 3;
  localparam int ST_LOWER   = 4;
  localparam int ST_DISPLAY = 5;
  localparam int ST_DELAY   = 6;
  localparam int ST_BUFFER  = 7;
  localparam int ST_REPEAT  = 8;
  localparam int ST_SWEEP   = 9;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {EXIT_FULL, EXIT_HALF, EXIT_JUMP} exit_e;
  typedef enum logic [2:0] {
    S_STOP, S_RNI, S_MEM, S_CHECK, S_EXEC, S_WAIT
  } run_state_e;

endpackage

// ===== dv/console_props.sv
`timescale 1ns/1ns
module console_props (
  // watched ports
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        sweep_sw,
  input wire logic        mem_req,
  input wire logic        exec_req,
  input wire logic        display_on,
  input wire logic        ext_master_clear,
  input wire logic        even_phase,
  input wire logic        odd_phase,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_phase_anti: assert property (even_phase != odd_phase)
    else $error("clock phases not opposite");
  a_phase_width: assert property (
    $rose(even_phase) |-> ##10 $fell(even_phase))
    else $error("even phase not ten cycles");
  a_display_idle: assert property (
    display_on |-> !mem_req && !exec_req)
    else $error("display lit while running");
  a_delay_quiet: assert property (
    $fell(display_on) |-> (!mem_req && !exec_req) [*8])
    else $error("work started before delay");
  a_sweep_noexec: assert property (
    $rose(exec_req) |-> !($past(sweep_sw, 4) && $past(sweep_sw, 8)))
    else $error("instruction executed in sweep");
  a_xclr_pulse: assert property (
    ext_master_clear |=> !ext_master_clear)
    else $error("external clear longer than one cycle");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule

bind console_run_control console_props props_u (
  .clk, .rst_n, .sweep_sw, .mem_req, .exec_req, .display_on,
  .ext_master_clear, .even_phase, .odd_phase, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// ===== dv/far_side.sv
`timescale 1ns/1ns
module far_side
  import console_pkg::*;
(
  // clock, reset, pacing
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           slow,
  input  wire logic                           ext_master_clear,
  // storage
  input  wire logic                           mem_req,
  input  wire logic [console_pkg::ADDR_W-1:0] mem_addr,
  output logic                                mem_ack,
  output logic [console_pkg::WORD_W-1:0]      mem_rdata,
  // execution unit
  input  wire logic                           exec_req,
  input  wire logic [console_pkg::HALF_W-1:0] exec_instr,
  output logic                                exec_done,
  output logic                                exec_cond,
  output logic                                exec_stop
);
  logic [WORD_W-1:0] mem [64] = '{default: '0};
  int                wait_cnt;
  // opcode 0 acts as a program stop here; bit 0 is the skip condition
  assign exec_cond = exec_instr[0];
  assign exec_stop = exec_instr[23:18] == 6'h00;
  always @(posedge clk or negedge rst_n) begin
    mem_ack   <= 1'b0;
    exec_done <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst_n || ext_master_clear) begin
      wait_cnt  <= 0;
      mem_rdata <= '0;
    end else if ((mem_req && !mem_ack) || (exec_req && !exec_done)) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= (slow ? 5 : 0)) begin
        wait_cnt  <= 0;
        mem_ack   <= mem_req;
        exec_done <= exec_req && !mem_req;
        mem_rdata <= mem[mem_addr[5:0]];
      end
    end
  end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import console_pkg::*;
  logic        clk, rst_n, start_sw, step_sw, neutral_sw, clear_dn_sw;
  logic        repeat_sw, sweep_sw, buffer_active, slow, exec_lower;
  logic        mem_req, mem_ack, exec_req, exec_done, exec_cond, exec_stop;
  logic        display_on, ext_master_clear, clear_up_sw;
  logic [2:0]  sel_jump_sw, sel_stop_sw;
  logic [14:0] mem_addr;
  logic [47:0] mem_rdata;
  logic [23:0] exec_instr;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          n_fail, tests_run, n;

  console_run_control #(.DELAY_TICKS(3)) dut_u (
    .clk, .rst_n, .start_sw, .step_sw, .neutral_sw, .clear_dn_sw,
    .clear_up_sw, .sel_jump_sw, .sel_stop_sw,
    .repeat_sw, .sweep_sw, .buffer_active, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata, .exec_req, .exec_instr, .exec_lower, .exec_done, .exec_cond,
    .exec_load_p(1'b0), .exec_addr(15'h0000), .exec_half(1'b0), .exec_stop,
    .display_on, .ext_master_clear, .even_phase(), .odd_phase(),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  far_side far_u (.clk, .rst_n, .slow, .ext_master_clear, .mem_req,
    .mem_addr, .mem_ack, .mem_rdata, .exec_req, .exec_instr, .exec_done,
    .exec_cond, .exec_stop);

  always #10 clk = ~clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_on, w_on;
    aw_on = 1'b1;
    w_on  = 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (aw_on || w_on) begin
      @(posedge clk);
      if (s_axi_awready) aw_on = 1'b0;
      if (s_axi_wready)  w_on  = 1'b0;
      s_axi_awvalid <= aw_on;
      s_axi_wvalid  <= w_on;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready  <= 1'b1;
    @(posedge clk);
    s_axi_bready  <= 1'b0;
  endtask
  // rready raised late on purpose so the slave must hold its answer
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] m,
                            input logic [31:0] e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready  <= 1'b1;
    @(posedge clk);
    s_axi_rready  <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, a > PCR_OFF ? RESP_SLVERR : RESP_OKAY);
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
    for (int k = 0; k < 4000 && display_on !== 1'b1; k++) @(posedge clk);
  endtask
  task automatic cmd(input int b);
    axi_wr(CTRL_OFF, 32'h1 << b);
    settle();
  endtask
  task automatic throw(input logic is_step);
    neutral_sw <= 1'b0;
    step_sw    <= is_step;
    start_sw   <= !is_step;
    repeat (50) @(posedge clk);
    step_sw    <= 1'b0;
    start_sw   <= 1'b0;
    neutral_sw <= 1'b1;
    settle();
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    {clk, rst_n, start_sw, step_sw, clear_dn_sw, repeat_sw, clear_up_sw} = '0;
    {sweep_sw, buffer_active, slow, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, n_fail, tests_run} = '0;
    {neutral_sw, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {1'b1, 48'h0};
    {sel_jump_sw, sel_stop_sw} = 6'h08;
    far_u.mem[16] = {24'h040001, 24'h080002};
    far_u.mem[17] = {OP_SKIP36, 18'h00001, 24'h000000};
    far_u.mem[18] = {24'h040001, OP_JUMP, 3'h1, 15'h0014};
    far_u.mem[19] = {24'h000000, 24'h040001};
    far_u.mem[20] = {OP_STOP, 3'h1, 15'h0016, 24'h000000};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    expect_reg(PADDR_OFF, 32'h7fff, 32'h10);
    expect_reg(STATUS_OFF, 32'h22, 32'h22);
    expect_reg(8'h10, 32'hffffffff, 32'h0);
    throw(1'b1);
    expect_reg(STATUS_OFF, 32'h0b, 32'h08);
    cmd(CTRL_STEP);
    expect_reg(STATUS_OFF, 32'h1b, 32'h18);
    slow <= 1'b1;
    cmd(CTRL_RUN);
    expect_reg(PADDR_OFF, 32'h7fff, 32'h16);
    slow <= 1'b0;
    clear_dn_sw <= 1'b1;
    repeat (20) @(posedge clk);
    clear_dn_sw <= 1'b0;
    expect_reg(STATUS_OFF, 32'h03, 32'h02);
    sel_stop_sw <= 3'h1;
    throw(1'b0);
    expect_reg(PADDR_OFF, 32'h7fff, 32'h16);
    expect_reg(PCR_OFF, 32'hffffff, 32'hf88016);
    cmd(CTRL_MCLR);
    repeat_sw <= 1'b1;
    repeat (3) cmd(CTRL_STEP);
    expect_reg(PADDR_OFF, 32'h7fff, 32'h10);
    repeat_sw <= 1'b0;
    cmd(CTRL_MCLR);
    sweep_sw <= 1'b1;
    cmd(CTRL_STEP);
    expect_reg(PCR_OFF, 32'hffffff, 32'h040001);
    cmd(CTRL_STEP);
    expect_reg(PCR_OFF, 32'hffffff, 32'h080002);
    cmd(CTRL_STEP);
    expect_reg(PADDR_OFF, 32'h7fff, 32'h11);
    sweep_sw <= 1'b0;
    cmd(CTRL_MCLR);
    buffer_active <= 1'b1;
    axi_wr(CTRL_OFF, 32'h3);
    repeat (200) @(posedge clk);
    expect_reg(STATUS_OFF, 32'h05, 32'h04);
    buffer_active <= 1'b0;
    n = 0;
    fork
      axi_wr(CTRL_OFF, 32'h1 << CTRL_XCLR);
      repeat (20) @(posedge clk) n += ext_master_clear;
    join
    clear_up_sw <= 1'b1;
    repeat (20) @(posedge clk) n += ext_master_clear;
    chk(n, 2);
    end_of_test();
  end
endmodule
